// file: gst_pkg.sv
/*
 * Package for the gated sixteen-bit timer: register offsets, field
 * positions, reset values and shared types.
 * Assumes a 32-bit AXI4-Lite register bus, one aligned word per register.
 */
`default_nettype none
package gst_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_TIMER_CONTROL = 8'h00;
	localparam logic [7:0] OFS_GATE_CONTROL  = 8'h04;
	localparam logic [7:0] OFS_COUNT_LOW     = 8'h08;
	localparam logic [7:0] OFS_COUNT_HIGH    = 8'h0c;
	localparam logic [7:0] OFS_CLK_PIN_SEL   = 8'h10;
	localparam logic [7:0] OFS_GATE_PIN_SEL  = 8'h14;
	localparam logic [7:0] OFS_IRQ_STATUS    = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK      = 8'h1c;
	// Timer control fields
	localparam int CTL_ON_BIT    = 0;
	localparam int CTL_SYNCD_BIT = 2;
	localparam int CTL_SOSC_BIT  = 3;
	localparam int CTL_PS_LSB    = 4;
	localparam int CTL_CS_LSB    = 6;
	// Gate control fields
	localparam int GCT_POL_BIT   = 6;
	localparam int GCT_EN_BIT    = 7;
	// Pin select field width
	localparam int PIN_SEL_W     = 5;
	// Reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_GATE    = 8'h00;
	localparam logic [15:0] RST_COUNT  = 16'h0000;
	localparam logic [7:0] RST_PIN_SEL = 8'h00;
	localparam logic [2:0] PS_MAX      = 3'h7;
	// Clock source choices
	typedef enum logic [1:0] {
		GST_SRC_SYS  = 2'h0,
		GST_SRC_SYS4 = 2'h1,
		GST_SRC_EXT  = 2'h2,
		GST_SRC_SOSC = 2'h3
	} gst_src_e;
	// AXI4-Lite response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// External pins that travel together
	typedef struct packed {
		logic [31:0] clk_pins;
		logic [31:0] gate_pins;
		logic        crystal_in;
	} gst_pins_s;
endpackage
`default_nettype wire

// file: gst_timer.sv
/*
 * Gated sixteen-bit timer with prescaler, crystal oscillator enable,
 * external clock synchroniser used in both sync settings, gate and overflow interrupt, on AXI4-Lite.
 * Assumes external clock, gate and crystal levels arrive asynchronously
 * and are slow compared with aclk.
 */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Crystal oscillator enabled only when enable bit set
// - Oscillator keeps running while processor sleeps
// - Overflow flag sets when count rolls over
// - Prescaler divides input by 1,2,4,8
// - Prescaler hidden; count byte write clears it
// - Sync disable still takes external clock from synchroniser
// - Unsynced external count continues; overflow wakes
// - Sync setting switch neither skips nor adds increment
// - Count byte reads always return valid value
// - Gate controls counting only when enabled
// - Gate polarity bit selects active level
// - Active gate: increment on source rising edge
// - Inactive gate: hold count unchanged
module gst_timer
(
	// Clock, enable and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                clk_en,
	// AXI4-Lite write channels
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// External pins and sleep indication
	input  wire gst_pkg::gst_pins_s  pins,
	input  wire logic                sleep,
	// Oscillator and interrupt outputs
	output logic                     secondary_osc_enable,
	output logic                     crystal_out,
	output logic                     irq
);
	import gst_pkg::*;
	// Software registers
	logic [7:0]  ctl_r;                 // Timer control
	logic [7:0]  gct_r;                 // Gate control
	logic [15:0] count_r;               // Sixteen-bit count
	logic [7:0]  cpin_r;                // Clock input pin select
	logic [7:0]  gpin_r;                // Gate input pin select
	logic        sts_r;                 // Sticky overflow flag
	logic        mask_r;                // Interrupt mask
	logic [2:0]  pre_r;                 // Hidden prescale counter
	logic [1:0]  sys4_r;                // Divider for system/4 source
	// Synchronisers: first stage read only by the second
	logic [2:0]  s1_r;
	logic [2:0]  s2_r;
	logic        src_q_r;               // Previous selected source level
	logic        asyn_q_r;              // Previous selected source level, for sync disable
	// Bus state
	logic        aw_ok_r;
	logic        w_ok_r;
	logic [7:0]  awa_r;
	logic [31:0] wd_r;
	logic [3:0]  ws_r;
	// Decode of the fields
	logic        f_on;
	logic        f_syncd;
	logic        f_sosc;
	logic [1:0]  f_ps;
	gst_src_e    f_cs;
	assign f_on    = ctl_r[CTL_ON_BIT];
	assign f_syncd = ctl_r[CTL_SYNCD_BIT];
	assign f_sosc  = ctl_r[CTL_SOSC_BIT];
	assign f_ps    = ctl_r[CTL_PS_LSB +: 2];
	assign f_cs    = gst_src_e'(ctl_r[CTL_CS_LSB +: 2]);
	// Bit chosen by a five-bit pin select field
	function automatic logic pick(input logic [31:0] v,
		input logic [7:0] sel);
		pick = v[sel[PIN_SEL_W-1:0]];
	endfunction
	// Raw levels brought into the aclk domain
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s1_r <= 3'h0;
			s2_r <= 3'h0;
		end
		else if (clk_en)
		begin
			s1_r <= {pick(pins.gate_pins, gpin_r),
				pins.crystal_in, pick(pins.clk_pins, cpin_r)};
			s2_r <= s1_r;
		end
	end
	logic gate_input;
	logic counter_clock;
	logic src_edge;
	logic gate_ok;
	assign gate_input = s2_r[2];
	// Crystal only counts when its oscillator is enabled
	always_comb
	begin
		case (f_cs)
			GST_SRC_SYS:  counter_clock = 1'b1;
			GST_SRC_SYS4: counter_clock = (sys4_r == 2'h3);
			GST_SRC_EXT:  counter_clock = s2_r[0];
			GST_SRC_SOSC: counter_clock = s2_r[1] & f_sosc;
			default:      counter_clock = 1'b0;
		endcase
	end
	// Sync disable: external edge taken from the second stage directly
	// without extra phase alignment, against the same edge history as the
	// synced path, so switching modes neither drops nor adds an increment.
	always_comb
	begin
		if (f_cs == GST_SRC_SYS)
			src_edge = 1'b1;
		else if (f_cs == GST_SRC_SYS4)
			src_edge = counter_clock;
		else if (f_syncd)
			src_edge = counter_clock & ~asyn_q_r;
		else
			src_edge = counter_clock & ~src_q_r;
	end
	// Gate level must equal the polarity bit when gating is enabled
	assign gate_ok = !gct_r[GCT_EN_BIT] ||
		(gate_input == gct_r[GCT_POL_BIT]);

	// Edge history and system/4 divider
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			src_q_r  <= 1'b0;
			asyn_q_r <= 1'b0;
			sys4_r   <= 2'h0;
		end
		else if (clk_en)
		begin
			src_q_r  <= counter_clock;
			asyn_q_r <= counter_clock;
			sys4_r   <= sys4_r + 2'h1;
		end
	end

	// Write acceptance
	logic wr_go;
	logic wr_lo;
	logic wr_hi;
	assign wr_go = aw_ok_r && w_ok_r && !s_axi_bvalid;
	assign wr_lo = wr_go && awa_r == OFS_COUNT_LOW && ws_r[0];
	assign wr_hi = wr_go && awa_r == OFS_COUNT_HIGH && ws_r[0];

	// Prescaler, count and overflow. Sleep does not stop external or
	// crystal counting since neither depends on the core clock.
	logic tick;
	logic pre_done;
	assign pre_done = (pre_r & ((3'h1 << f_ps) - 3'h1)) ==
		((3'h1 << f_ps) - 3'h1);
	assign tick = f_on && gate_ok && src_edge && !(sleep &&
		(f_cs == GST_SRC_SYS || f_cs == GST_SRC_SYS4));
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pre_r   <= 3'h0;
			count_r <= RST_COUNT;
		end
		else if (clk_en)
		begin
			if (wr_lo || wr_hi)
				pre_r <= 3'h0;
			else if (tick)
				pre_r <= pre_done ? 3'h0 : pre_r + 3'h1;
			// Byte writes replace one byte; a write wins over a tick,
			// software is expected to stop the counter first.
			if (wr_lo)
				count_r[7:0] <= wd_r[7:0];
			else if (wr_hi)
				count_r[15:8] <= wd_r[7:0];
			else if (tick && pre_done)
				count_r <= count_r + 16'h1;
		end
	end

	// Overflow set, write-one-to-clear; set wins over clear
	logic ovf;
	assign ovf = tick && pre_done && count_r == 16'hffff && !wr_lo &&
		!wr_hi;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sts_r <= 1'b0;
		else if (clk_en)
		begin
			if (ovf)
				sts_r <= 1'b1;
			else if (wr_go && awa_r == OFS_IRQ_STATUS && ws_r[0] &&
				wd_r[0])
				sts_r <= 1'b0;
		end
	end

	// Control registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctl_r  <= RST_CONTROL;
			gct_r  <= RST_GATE;
			cpin_r <= RST_PIN_SEL;
			gpin_r <= RST_PIN_SEL;
			mask_r <= 1'b0;
		end
		else if (clk_en && wr_go && ws_r[0])
		begin
			case (awa_r)
				OFS_TIMER_CONTROL: ctl_r  <= wd_r[7:0] & 8'hfd;
				OFS_GATE_CONTROL:  gct_r  <= wd_r[7:0] & 8'hc0;
				OFS_CLK_PIN_SEL:   cpin_r <= wd_r[7:0] & 8'h1f;
				OFS_GATE_PIN_SEL:  gpin_r <= wd_r[7:0] & 8'h1f;
				OFS_IRQ_MASK:      mask_r <= wd_r[0];
				default:           ;
			endcase
		end
	end

	// Known address check
	function automatic logic known(input logic [7:0] a);
		known = (a[1:0] == 2'h0) && (a <= OFS_IRQ_MASK);
	endfunction

	// Write channel handshake: address and data in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			aw_ok_r       <= 1'b0;
			w_ok_r        <= 1'b0;
			awa_r         <= 8'h00;
			wd_r          <= 32'h0;
			ws_r          <= 4'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end
		else if (clk_en)
		begin
			s_axi_awready <= !aw_ok_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_ok_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_ok_r <= 1'b1;
				awa_r   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_ok_r <= 1'b1;
				wd_r   <= s_axi_wdata;
				ws_r   <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_ok_r      <= 1'b0;
				w_ok_r       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= known(awa_r) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel: count is sampled in aclk so both bytes read valid
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0;
		case (s_axi_araddr)
			OFS_TIMER_CONTROL: rd_mux[7:0] = ctl_r;
			OFS_GATE_CONTROL:  rd_mux[7:0] = {gct_r[7:6], 3'h0,
				gate_input, 2'h0};
			OFS_COUNT_LOW:     rd_mux[7:0] = count_r[7:0];
			OFS_COUNT_HIGH:    rd_mux[7:0] = count_r[15:8];
			OFS_CLK_PIN_SEL:   rd_mux[7:0] = cpin_r;
			OFS_GATE_PIN_SEL:  rd_mux[7:0] = gpin_r;
			OFS_IRQ_STATUS:    rd_mux[0]   = sts_r;
			OFS_IRQ_MASK:      rd_mux[0]   = mask_r;
			default:           rd_mux      = 32'h0;
		endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (clk_en)
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
				s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_mux;
				s_axi_rresp  <= known(s_axi_araddr) ? RESP_OKAY :
					RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Outputs from flops: oscillator drive and interrupt level
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			secondary_osc_enable <= 1'b0;
			crystal_out          <= 1'b0;
			irq                  <= 1'b0;
		end
		else if (clk_en)
		begin
			secondary_osc_enable <= f_sosc;
			crystal_out          <= f_sosc & ~s2_r[1];
			irq                  <= sts_r & mask_r;
		end
	end

	// Checks
	sequence s_wrap;
		tick && pre_done && count_r == 16'hffff && !wr_lo && !wr_hi;
	endsequence
	property p_ovf;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en and s_wrap) |=> sts_r && count_r == 16'h0000;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow missed");
	property p_hold_off;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en && !f_on && !wr_lo && !wr_hi) |=> $stable(count_r);
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("counted off");
	property p_gate;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en && gct_r[GCT_EN_BIT] && gate_input != gct_r[GCT_POL_BIT]
		&& !wr_lo && !wr_hi) |=> $stable(count_r);
	endproperty
	a_gate: assert property (p_gate) else $error("gate ignored");
	property p_pre_clr;
		@(posedge aclk) disable iff (!aresetn)
		clk_en && (wr_lo || wr_hi) |=> pre_r == 3'h0;
	endproperty
	a_pre_clr: assert property (p_pre_clr) else $error("prescale kept");
	property p_byte;
		@(posedge aclk) disable iff (!aresetn)
		clk_en && wr_lo |=> count_r[7:0] == $past(wd_r[7:0]) &&
		count_r[15:8] == $past(count_r[15:8]);
	endproperty
	a_byte: assert property (p_byte) else $error("byte write bad");
	property p_pre;
		@(posedge aclk) disable iff (!aresetn)
		clk_en && tick && !pre_done && !wr_lo && !wr_hi |=>
		$stable(count_r);
	endproperty
	a_pre: assert property (p_pre) else $error("prescale skipped");
	property p_osc;
		@(posedge aclk) disable iff (!aresetn)
		clk_en && !f_sosc && f_cs == GST_SRC_SOSC |-> !counter_clock;
	endproperty
	a_osc: assert property (p_osc) else $error("osc off counted");
	property p_irq;
		@(posedge aclk) disable iff (!aresetn)
		clk_en && sts_r && mask_r |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing");
endmodule // gst_timer
`default_nettype wire

// file: gst_ext_src.sv
/*
 * Far-side model of the timer: external clock pulses, gate level and a
 * crystal on the oscillator pins.
 * Assumes the bench picks the pin indices and the gate level.
 */
`timescale 1ns/1ps
`default_nettype none
module gst_ext_src
	import gst_pkg::*;
#(
	parameter int XT_HALF = 6	// Crystal half period in aclk cycles
)
(
	// Clock
	input  wire logic          aclk,
	// Bench controls
	input  wire logic [4:0]    clk_idx,
	input  wire logic [4:0]    gate_idx,
	input  wire logic          gate_lvl,
	// Amplifier enable from the device
	input  wire logic          osc_en,
	// Pin levels
	output var gst_pkg::gst_pins_s pins
);
	logic        ext_clk = 1'b0;	// Idle low between bursts
	logic [31:0] noise   = 32'h1;	// Unselected pins, new value each cycle
	logic        xtal    = 1'b0;	// Crystal node
	int          xt_cnt  = 0;	// Crystal phase count

	// Unselected pins move so a wrong pin select shows up as extra counts
	always @(posedge aclk)
		noise <= {noise[30:0], ~noise[31]};

	// Crystal swings only with the amplifier on, whether asleep or not
	always @(posedge aclk)
	begin
		xt_cnt <= (osc_en && xt_cnt < XT_HALF - 1) ? xt_cnt + 1 : 0;
		if (!osc_en)
			xtal <= 1'b0;
		else if (xt_cnt == XT_HALF - 1)
			xtal <= ~xtal;
	end

	// Selected pins carry the clock and the gate
	always_comb
	begin
		pins.clk_pins            = noise;
		pins.clk_pins[clk_idx]   = ext_clk;
		pins.gate_pins           = ~noise;
		pins.gate_pins[gate_idx] = gate_lvl;
		pins.crystal_in          = xtal;
	end

	// Sends n rising edges; each phase lasts w cycles, long enough to sync
	task automatic pulses(input int n, input int w);
		repeat (n)
		begin
			repeat (w) @(posedge aclk);
			ext_clk <= 1'b1;
			repeat (w) @(posedge aclk);
			ext_clk <= 1'b0;
		end
	endtask
endmodule // gst_ext_src
`default_nettype wire

// file: gst_timer_tb.sv
/*
 * Self-checking bench for the gated timer over AXI4-Lite.
 * Assumes the far-side model gst_ext_src and the package constants.
 */
`timescale 1ns/1ps
`default_nettype none
module gst_timer_tb;
	import gst_pkg::*;
	// Clock, reset, sleep
	logic        aclk     = 1'b0;
	logic        aresetn  = 1'b0;
	logic        sleep    = 1'b0;
	// Bus master signals
	logic [7:0]  awaddr   = 8'h00;
	logic        awvalid  = 1'b0;
	logic [31:0] wdata    = 32'h0;
	logic        wvalid   = 1'b0;
	logic        bready   = 1'b0;
	logic [7:0]  araddr   = 8'h00;
	logic        arvalid  = 1'b0;
	logic        rready   = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata, rd_v;
	// Far side and outputs
	gst_pins_s   pins;
	logic        osc_en, xt_out, irq;
	logic [4:0]  clk_idx  = 5'h00;
	logic [4:0]  gate_idx = 5'h00;
	logic        gate_lvl = 1'b0;
	logic [4:0]  ci, gi;
	logic        sd, on, ge;
	// Model and bookkeeping
	int          n_fail = 0, n_tests = 0, cycles = 0, k, st, model;

	always #20 aclk = ~aclk;

	gst_timer i_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins(pins),
		.sleep(sleep), .secondary_osc_enable(osc_en),
		.crystal_out(xt_out), .irq(irq));

	gst_ext_src i_src (.aclk(aclk), .clk_idx(clk_idx), .gate_idx(gate_idx),
		.gate_lvl(gate_lvl), .osc_en(osc_en), .pins(pins));

	// Prints the verdict and ends the run
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Compares one value with its expectation
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			$display("Error at %0t seen %h expected %h", $time, seen, exp);
			n_fail++;
		end
	endtask

	// One bus transfer; entered just after a clock edge
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int t;
		t = 0;
		awaddr  <= a;
		araddr  <= a;
		wdata   <= d;
		awvalid <= wr;
		wvalid  <= wr;
		bready  <= wr;
		arvalid <= !wr;
		rready  <= !wr;
		do
		begin
			@(posedge aclk);
			t++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (arready)
				arvalid <= 1'b0;
		end
		while (!(wr ? bvalid : rvalid) && t < 64);
		bready <= 1'b0;
		rready <= 1'b0;
		resp = wr ? bresp : rresp;
		rd_v = rdata;
		chk(32'(t < 64), 32'h1);
		// Let one edge pass so the next call never re-drives a strobe
		// in the time step that released it
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd_v, exp);
	endtask

	// Control word: source, prescale, oscillator, sync off, counter on
	function automatic logic [31:0] ctl(input gst_src_e s, input int ps,
		input logic osc, input logic sdis, input logic run);
		return {24'h0, s, 2'(ps), osc, sdis, 1'b0, run};
	endfunction

	// Hang guard
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			n_fail++;
			stop_test();
		end
	end

	initial
	begin
		void'($urandom(32'h144fb426));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// Reset values, then refused addresses
		for (int a = 0; a < 32; a += 4)
			rd(8'(a), 32'h0);
		bus(1'b0, 8'h20, 32'h0);
		chk(32'(resp), 32'(RESP_SLVERR));
		bus(1'b1, 8'h0a, 32'h1);
		chk(32'(resp), 32'(RESP_SLVERR));
		// Pulse counts through every prescale, gate case and the on bit
		for (int i = 0; i < 12; i++)
		begin
			ci = 5'($urandom);
			gi = 5'($urandom);
			sd = 1'($urandom);
			on = (i != 5);
			ge = (i >= 4);
			k  = 8 + $urandom % 24;
			st = $urandom % 65536;
			clk_idx  <= ci;
			gate_idx <= gi;
			gate_lvl <= i[1];
			bus(1'b1, OFS_TIMER_CONTROL, ctl(GST_SRC_EXT, i % 4, 0, sd, 0));
			bus(1'b1, OFS_CLK_PIN_SEL, 32'(ci));
			bus(1'b1, OFS_GATE_PIN_SEL, 32'(gi));
			bus(1'b1, OFS_GATE_CONTROL, {24'h0, ge, i[0], 6'h0});
			bus(1'b1, OFS_COUNT_LOW, 32'(st % 256));
			bus(1'b1, OFS_COUNT_HIGH, 32'(st / 256));
			bus(1'b1, OFS_TIMER_CONTROL, ctl(GST_SRC_EXT, i % 4, 0, sd, on));
			i_src.pulses(k, 3 + $urandom % 3);
			repeat (8) @(posedge aclk);
			bus(1'b1, OFS_TIMER_CONTROL, ctl(GST_SRC_EXT, i % 4, 0, sd, 0));
			model = st + ((on && (!ge || i[0] == i[1])) ? (k >> (i % 4)) : 0);
			rd(OFS_COUNT_LOW, 32'(model % 256));
			rd(OFS_COUNT_HIGH, 32'((model / 256) % 256));
		end
		// Rollover from FC00 after exactly 1024 edges, asleep, unsynced
		bus(1'b1, OFS_GATE_CONTROL, 32'h0);
		bus(1'b1, OFS_IRQ_STATUS, 32'h1);
		bus(1'b1, OFS_IRQ_MASK, 32'h0);
		bus(1'b1, OFS_COUNT_LOW, 32'h0);
		bus(1'b1, OFS_COUNT_HIGH, 32'hfc);
		bus(1'b1, OFS_TIMER_CONTROL, ctl(GST_SRC_EXT, 0, 0, 1, 1));
		sleep <= 1'b1;
		i_src.pulses(1023, 3);
		repeat (8) @(posedge aclk);
		rd(OFS_IRQ_STATUS, 32'h0);
		i_src.pulses(1, 3);
		repeat (8) @(posedge aclk);
		rd(OFS_IRQ_STATUS, 32'h1);
		chk(32'(irq), 32'h0);
		bus(1'b1, OFS_IRQ_MASK, 32'h1);
		repeat (2) @(posedge aclk);
		chk(32'(irq), 32'h1);
		bus(1'b1, OFS_IRQ_STATUS, 32'h1);
		repeat (2) @(posedge aclk);
		chk(32'(irq), 32'h0);
		// System sources halt while asleep, and system/4 counts once awake
		bus(1'b1, OFS_TIMER_CONTROL, ctl(GST_SRC_SYS, 0, 0, 0, 1));
		bus(1'b1, OFS_TIMER_CONTROL, ctl(GST_SRC_SYS4, 0, 0, 0, 1));
		repeat (20) @(posedge aclk);
		bus(1'b1, OFS_TIMER_CONTROL, ctl(GST_SRC_SYS4, 0, 0, 0, 0));
		rd(OFS_COUNT_LOW, 32'h0);
		sleep <= 1'b0;
		bus(1'b1, OFS_TIMER_CONTROL, ctl(GST_SRC_SYS4, 0, 0, 0, 1));
		repeat (40) @(posedge aclk);
		bus(1'b1, OFS_TIMER_CONTROL, ctl(GST_SRC_SYS4, 0, 0, 0, 0));
		bus(1'b0, OFS_COUNT_LOW, 32'h0);
		chk(32'(rd_v >= 32'h0a), 32'h1);
		sleep <= 1'b1;
		// Crystal source keeps counting while asleep
		bus(1'b1, OFS_TIMER_CONTROL, ctl(GST_SRC_SOSC, 0, 1, 0, 0));
		chk(32'(osc_en), 32'h1);
		bus(1'b1, OFS_COUNT_LOW, 32'h0);
		bus(1'b1, OFS_COUNT_HIGH, 32'h0);
		bus(1'b1, OFS_TIMER_CONTROL, ctl(GST_SRC_SOSC, 0, 1, 0, 1));
		// Amplifier output inverts the crystal, roughly half the time high
		k = 0;
		repeat (300)
		begin
			@(posedge aclk);
			k += xt_out;
		end
		chk(32'(k > 100 && k < 200), 32'h1);
		bus(1'b1, OFS_TIMER_CONTROL, ctl(GST_SRC_SOSC, 0, 0, 0, 0));
		chk(32'(osc_en), 32'h0);
		chk(32'(xt_out), 32'h0);
		bus(1'b0, OFS_COUNT_LOW, 32'h0);
		chk(32'(rd_v != 32'h0), 32'h1);
		sleep <= 1'b0;
		stop_test();
	end
endmodule // gst_timer_tb
`default_nettype wire
